// File: design/cfgci_top.sv
// Configuration command interpreter: host mailbox commands and boot stream.
// Assumes boot words arrive one per valid pulse; register file lives outside.
`timescale 1ns/1ps
`default_nettype none
module cfgci_top #(
   parameter int MAX_LIST = 4095
) (
   // Clock and reset
   input  wire logic                  clk_sys,
   input  wire logic                  rst,
   // Host serial port
   input  wire cfgci_pkg::cfgci_spi_t spiIn,
   // Boot stream
   input  wire logic                  bootMode,
   input  wire logic                  bootValid,
   input  wire logic [23:0]           bootWord,
   // Register read data from filter register file
   input  wire logic [23:0]           regRdData,
   // Outputs to filter
   output cfgci_pkg::cfgci_store_t    store,
   output cfgci_pkg::cfgci_ctl_t      ctl,
   output logic                       running,
   output logic [23:0]                waveCount,
   output logic [11:0]                regRdIndex,
   output logic [23:0]                hostDat1,
   output logic                       busy
);
   if (MAX_LIST < 1 || MAX_LIST > 4095) begin : g_bad_list
      $error("MAX_LIST out of range");
   end

   logic [23:0] cmdWord;
   logic [23:0] dat1Word;
   logic [23:0] dat2Word;
   logic        cmdStrobe;
   logic        rdPend_ff;

   cfgci_mailbox u_mailbox (
      .clk_sys     (clk_sys),
      .rst         (rst),
      .spiIn       (spiIn),
      .readBack    (regRdData),
      .readBackVld (rdPend_ff),
      .cmdWord     (cmdWord),
      .dat1Word    (dat1Word),
      .dat2Word    (dat2Word),
      .cmdStrobe   (cmdStrobe)
   );

   cfgci_pkg::cfgci_state_t state_ff;
   cfgci_pkg::cfgci_state_t nxt_state;
   cfgci_pkg::cfgci_dst_t   dst_ff;
   logic [7:0]  op_ff;
   logic [23:0] arg1_ff;
   logic [11:0] remain_ff;
   logic [11:0] idx_ff;
   logic        running_ff;
   logic [23:0] waveCnt_ff;
   cfgci_pkg::cfgci_store_t store_ff;
   cfgci_pkg::cfgci_ctl_t   ctl_ff;
   logic [11:0] rdIdx_ff;
   logic        busy_ff;

   // Host decode: one whole command per strobe
   wire hostWr  = cmdStrobe && cmdWord == cfgci_pkg::HC_WRREG;
   wire hostRd  = cmdStrobe && cmdWord == cfgci_pkg::HC_RDREG;
   wire hostFir = cmdStrobe && cmdWord == cfgci_pkg::HC_FIR;
   wire hostIir = cmdStrobe && cmdWord == cfgci_pkg::HC_IIR;
   wire hostRom = cmdStrobe && cmdWord == cfgci_pkg::HC_ROMCOEF;
   wire hostTbs = cmdStrobe && cmdWord == cfgci_pkg::HC_TBS;
   wire hostRtb = cmdStrobe && cmdWord == cfgci_pkg::HC_ROMTBS;
   wire hostGo  = cmdStrobe && cmdWord == cfgci_pkg::HC_START;
   wire hostEnd = cmdStrobe && cmdWord == cfgci_pkg::HC_STOP;

   // Boot stream decode: opcode in low byte of an idle word
   wire [7:0] bootOp = bootWord[7:0];
   wire bootIdle = bootMode && bootValid && state_ff == cfgci_pkg::CFGCI_ST_IDLE;
   wire bootRtb  = bootIdle && bootOp == cfgci_pkg::EC_ROMTBS;
   wire bootGo   = bootIdle && bootOp == cfgci_pkg::EC_START;
   wire bootArgs = bootIdle && (bootOp == cfgci_pkg::EC_WRREG || bootOp == cfgci_pkg::EC_FIR
                   || bootOp == cfgci_pkg::EC_IIR || bootOp == cfgci_pkg::EC_ROMCOEF
                   || bootOp == cfgci_pkg::EC_TBS);
   wire bootData = bootMode && bootValid && state_ff != cfgci_pkg::CFGCI_ST_IDLE;
   // Host and boot are exclusive; while in boot, host strobes are ignored
   wire hostOk   = !bootMode;

   // Host list transfers reuse the mailbox: each later strobe of the same
   // code past the header carries two more list words.
   wire listBusy = state_ff == cfgci_pkg::CFGCI_ST_LIST;

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         cfgci_pkg::CFGCI_ST_IDLE: begin
            // IIR carries no count word: coefficients follow the opcode
            if (bootArgs) begin
               nxt_state = bootOp == cfgci_pkg::EC_IIR ? cfgci_pkg::CFGCI_ST_LIST
                                                       : cfgci_pkg::CFGCI_ST_ARG1;
            end
         end
         cfgci_pkg::CFGCI_ST_ARG1: begin
            if (bootData) begin
               if (op_ff == cfgci_pkg::EC_ROMCOEF) begin
                  nxt_state = cfgci_pkg::CFGCI_ST_IDLE;
               end else if (op_ff == cfgci_pkg::EC_TBS) begin
                  nxt_state = bootWord == 24'h00_0000 ? cfgci_pkg::CFGCI_ST_IDLE
                                                      : cfgci_pkg::CFGCI_ST_LIST;
               end else if (op_ff == cfgci_pkg::EC_IIR) begin
                  nxt_state = cfgci_pkg::CFGCI_ST_LIST;
               end else begin
                  nxt_state = cfgci_pkg::CFGCI_ST_ARG2;
               end
            end
         end
         cfgci_pkg::CFGCI_ST_ARG2: begin
            if (bootData) begin
               if (op_ff == cfgci_pkg::EC_WRREG) begin
                  nxt_state = cfgci_pkg::CFGCI_ST_IDLE;
               end else begin
                  // Same 12-bit sum as the list counter, so a wrapped total ends here
                  nxt_state = (arg1_ff[11:0] + bootWord[11:0] == 12'h000)
                              ? cfgci_pkg::CFGCI_ST_IDLE : cfgci_pkg::CFGCI_ST_LIST;
               end
            end
         end
         cfgci_pkg::CFGCI_ST_LIST: begin
            if (bootData && remain_ff == 12'h001) begin
               nxt_state = cfgci_pkg::CFGCI_ST_IDLE;
            end
         end
         default: nxt_state = cfgci_pkg::CFGCI_ST_IDLE;
      endcase
   end

   wire [11:0] bootCount = bootWord[11:0];
   wire [11:0] firTotal  = arg1_ff[11:0] + bootWord[11:0];

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state_ff <= cfgci_pkg::CFGCI_ST_IDLE;
         op_ff    <= cfgci_pkg::EC_NOP;
         arg1_ff  <= 24'h00_0000;
         remain_ff <= 12'h000;
         idx_ff   <= 12'h000;
         dst_ff   <= cfgci_pkg::CFGCI_DST_FIR;
         busy_ff  <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         busy_ff  <= nxt_state != cfgci_pkg::CFGCI_ST_IDLE;
         if (bootArgs) begin
            op_ff  <= bootOp;
            idx_ff <= 12'h000;
            dst_ff <= bootOp == cfgci_pkg::EC_IIR ? cfgci_pkg::CFGCI_DST_IIR :
                      bootOp == cfgci_pkg::EC_TBS ? cfgci_pkg::CFGCI_DST_TBS :
                                                    cfgci_pkg::CFGCI_DST_FIR;
            remain_ff <= bootOp == cfgci_pkg::EC_IIR ? 12'(cfgci_pkg::IIR_COEFS) : 12'h000;
         end else if (bootData) begin
            if (state_ff == cfgci_pkg::CFGCI_ST_ARG1) begin
               arg1_ff <= bootWord;
               if (op_ff == cfgci_pkg::EC_TBS) begin
                  remain_ff <= bootCount;
               end
            end else if (state_ff == cfgci_pkg::CFGCI_ST_ARG2) begin
               remain_ff <= firTotal;
            end else begin
               remain_ff <= remain_ff - 12'h001;
               idx_ff    <= idx_ff + 12'h001;
            end
         end else if (hostOk && (hostFir || hostTbs || hostIir)) begin
            idx_ff <= 12'h000;
         end else if (hostOk && listBusy) begin
            idx_ff <= idx_ff;
         end
      end
   end

   // Host list words: after the header strobe, each strobe of the same
   // code loads two more words (data one at idx, data two at idx+1).
   logic        hList_ff;
   logic [11:0] hIdx_ff;
   cfgci_pkg::cfgci_dst_t hDst_ff;
   cfgci_pkg::cfgci_dst_t hDstNow;
   wire hostList = hostFir || hostIir || hostTbs;
   assign hDstNow = hostIir ? cfgci_pkg::CFGCI_DST_IIR :
                    hostTbs ? cfgci_pkg::CFGCI_DST_TBS : cfgci_pkg::CFGCI_DST_FIR;
   // Only the same code continues a list; another code starts afresh
   wire hostCont = hList_ff && hostList && hDst_ff == hDstNow;
   wire hostPair = hostOk && (hostCont || hostIir);
   wire [11:0] hCur = hostCont ? hIdx_ff : 12'h000;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         hList_ff <= 1'b0;
         hIdx_ff  <= 12'h000;
         hDst_ff  <= cfgci_pkg::CFGCI_DST_FIR;
      end else if (hostOk && cmdStrobe) begin
         // IIR has no header: first strobe already carries a11/b10
         hList_ff <= hostList && !(hostIir && hCur == 12'(cfgci_pkg::IIR_COEFS - 2));
         hDst_ff  <= hDstNow;
         hIdx_ff  <= hostPair ? hCur + 12'h002 : 12'h000;
      end
   end

   // Store outputs and control pulses
   wire bootReg  = bootData && state_ff == cfgci_pkg::CFGCI_ST_ARG2
                   && op_ff == cfgci_pkg::EC_WRREG;
   wire bootCoef = bootData && state_ff == cfgci_pkg::CFGCI_ST_LIST;
   wire bootSel  = bootData && state_ff == cfgci_pkg::CFGCI_ST_ARG1
                   && op_ff == cfgci_pkg::EC_ROMCOEF;
   logic        pair2_ff;
   logic [23:0] pairDat_ff;
   logic [11:0] pairIdx_ff;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         store_ff   <= '0;
         ctl_ff     <= '0;
         running_ff <= 1'b0;
         waveCnt_ff <= 24'h00_0000;
         rdIdx_ff   <= 12'h000;
         rdPend_ff  <= 1'b0;
         pair2_ff   <= 1'b0;
         pairDat_ff <= 24'h00_0000;
         pairIdx_ff <= 12'h000;
      end else begin
         store_ff.regWr  <= bootReg || (hostOk && hostWr);
         store_ff.coefWr <= bootCoef || hostPair || pair2_ff;
         pair2_ff        <= hostPair;
         pairDat_ff      <= dat2Word;
         pairIdx_ff      <= hCur + 12'h001;
         if (bootReg) begin
            store_ff.index <= arg1_ff[11:0];
            store_ff.data  <= bootWord;
         end else if (bootCoef) begin
            store_ff.dst   <= dst_ff;
            store_ff.index <= idx_ff;
            store_ff.data  <= bootWord;
         end else if (hostOk && hostWr) begin
            store_ff.index <= dat1Word[11:0];
            store_ff.data  <= dat2Word;
         end else if (hostPair) begin
            store_ff.dst   <= hDstNow;
            store_ff.index <= hCur;
            store_ff.data  <= dat1Word;
         end else if (pair2_ff) begin
            store_ff.index <= pairIdx_ff;
            store_ff.data  <= pairDat_ff;
         end
         if (hostOk && hostTbs && !hostCont) begin
            waveCnt_ff <= dat1Word;
         end else if (bootData && state_ff == cfgci_pkg::CFGCI_ST_ARG1
                      && op_ff == cfgci_pkg::EC_TBS) begin
            waveCnt_ff <= bootWord;
         end
         ctl_ff.romTbs  <= bootRtb || (hostOk && hostRtb);
         ctl_ff.romCoef <= bootSel || (hostOk && hostRom);
         if (bootSel) begin
            ctl_ff.coefSel <= bootWord;
         end else if (hostOk && hostRom) begin
            ctl_ff.coefSel <= dat1Word;
         end
         ctl_ff.start <= bootGo || (hostOk && hostGo);
         ctl_ff.stop  <= hostOk && hostEnd;
         if (bootGo || (hostOk && hostGo)) begin
            running_ff <= 1'b1;
         end else if (hostOk && hostEnd) begin
            running_ff <= 1'b0;
         end
         // Read: index out, data captured next cycle into data one
         rdPend_ff <= hostOk && hostRd;
         if (hostOk && hostRd) begin
            rdIdx_ff <= dat1Word[11:0];
         end
      end
   end

   assign store      = store_ff;
   assign ctl        = ctl_ff;
   assign running    = running_ff;
   assign waveCount  = waveCnt_ff;
   assign regRdIndex = rdIdx_ff;
   assign hostDat1   = dat1Word;
   assign busy       = busy_ff;

   // Unknown codes and NOP leave configuration alone
   wire hostKnown = hostWr || hostRd || hostList || hostRom || hostRtb || hostGo || hostEnd;

   property p_nop_quiet;
      @(posedge clk_sys) disable iff (rst)
      (cmdStrobe && !hostKnown && !bootMode && !busy && !pair2_ff)
      |=> !store.regWr && !store.coefWr && !ctl.start && !ctl.stop;
   endproperty
   a_nop_quiet: assert property (p_nop_quiet) else $error("Unknown code acted");

   property p_host_write;
      @(posedge clk_sys) disable iff (rst)
      (hostWr && !bootMode) |=> store.regWr && store.data == $past(dat2Word);
   endproperty
   a_host_write: assert property (p_host_write) else $error("Register write lost");

   property p_read_back;
      @(posedge clk_sys) disable iff (rst)
      (hostRd && !bootMode) |=> rdPend_ff ##1 hostDat1 == $past(regRdData);
   endproperty
   a_read_back: assert property (p_read_back) else $error("Read data not returned");

   property p_start;
      @(posedge clk_sys) disable iff (rst)
      (hostGo && !bootMode) |=> running && ctl.start;
   endproperty
   a_start: assert property (p_start) else $error("Filter did not start");

   property p_stop;
      @(posedge clk_sys) disable iff (rst)
      (hostEnd && !bootMode && !hostGo) |=> !running ##1 !running || ctl.start;
   endproperty
   a_stop: assert property (p_stop) else $error("Filter did not stop");

   property p_rom_tbs;
      @(posedge clk_sys) disable iff (rst)
      bootRtb |=> ctl.romTbs && !store.coefWr;
   endproperty
   a_rom_tbs: assert property (p_rom_tbs) else $error("Waveform table not selected");

   sequence s_tbs_head;
      bootData && state_ff == cfgci_pkg::CFGCI_ST_ARG1 && op_ff == cfgci_pkg::EC_TBS
      && bootWord == 24'h00_0001;
   endsequence
   property p_tbs_one;
      @(posedge clk_sys) disable iff (rst)
      s_tbs_head |=> (state_ff == cfgci_pkg::CFGCI_ST_LIST && waveCount == 24'h00_0001);
   endproperty
   a_tbs_one: assert property (p_tbs_one) else $error("Waveform count wrong");

   property p_iir_count;
      @(posedge clk_sys) disable iff (rst)
      (bootIdle && bootOp == cfgci_pkg::EC_IIR) |=> remain_ff == 12'h008;
   endproperty
   a_iir_count: assert property (p_iir_count) else $error("IIR count wrong");

   property p_boot_running;
      @(posedge clk_sys) disable iff (rst)
      (bootMode && running) |=> running;
   endproperty
   a_boot_running: assert property (p_boot_running) else $error("Boot lost run state");
endmodule
`default_nettype wire

// File: common/cfgci_pkg.sv
// Constants and carrier types for the configuration command interpreter.
// Assumes one synchronous clock domain; users write package::name.
package cfgci_pkg;
   localparam int WORD_W = 24;
   localparam int OPC_W  = 8;

   // Host command codes
   localparam logic [23:0] HC_NOP     = 24'h00_0000;
   localparam logic [23:0] HC_WRREG   = 24'h00_0001;
   localparam logic [23:0] HC_RDREG   = 24'h00_0002;
   localparam logic [23:0] HC_FIR     = 24'h00_0003;
   localparam logic [23:0] HC_IIR     = 24'h00_0004;
   localparam logic [23:0] HC_ROMCOEF = 24'h00_0005;
   localparam logic [23:0] HC_TBS     = 24'h00_0006;
   localparam logic [23:0] HC_ROMTBS  = 24'h00_0007;
   localparam logic [23:0] HC_START   = 24'h00_0008;
   localparam logic [23:0] HC_STOP    = 24'h00_0009;

   // Boot opcodes
   localparam logic [7:0] EC_NOP     = 8'h00;
   localparam logic [7:0] EC_WRREG   = 8'h01;
   localparam logic [7:0] EC_FIR     = 8'h02;
   localparam logic [7:0] EC_IIR     = 8'h03;
   localparam logic [7:0] EC_ROMCOEF = 8'h04;
   localparam logic [7:0] EC_TBS     = 8'h05;
   localparam logic [7:0] EC_ROMTBS  = 8'h06;
   localparam logic [7:0] EC_START   = 8'h07;

   // Serial register map byte addresses of the mailbox
   localparam logic [7:0] SA_CMD  = 8'h03;
   localparam logic [7:0] SA_FIRST_DATA_WORD = 8'h06;
   localparam logic [7:0] SA_SECOND_DATA_WORD = 8'h09;
   localparam logic [7:0] SA_LAST = 8'h0B;

   localparam int IIR_COEFS = 8;

   typedef enum logic [2:0] {
      CFGCI_ST_IDLE = 3'b000,
      CFGCI_ST_ARG1 = 3'b001,
      CFGCI_ST_ARG2 = 3'b011,
      CFGCI_ST_LIST = 3'b010,
      CFGCI_ST_EXEC = 3'b110
   } cfgci_state_t;

   typedef enum logic [1:0] {
      CFGCI_DST_FIR = 2'b00,
      CFGCI_DST_IIR = 2'b01,
      CFGCI_DST_TBS = 2'b10
   } cfgci_dst_t;

   // One incoming byte write on the byte-wide serial port
   typedef struct packed {
      logic       wr;
      logic [7:0] addr;
      logic [7:0] data;
   } cfgci_spi_t;

   // One store into filter storage
   typedef struct packed {
      logic        regWr;
      logic        coefWr;
      cfgci_dst_t  dst;
      logic [11:0] index;
      logic [23:0] data;
   } cfgci_store_t;

   typedef struct packed {
      logic        start;
      logic        stop;
      logic        romTbs;
      logic        romCoef;
      logic [23:0] coefSel;
   } cfgci_ctl_t;
endpackage

// File: design/cfgci_mailbox.sv
// Host mailbox: assembles command and two data words from byte writes.
// Assumes bytes arrive MSB first at three consecutive addresses per word.
`timescale 1ns/1ps
`default_nettype none
module cfgci_mailbox (
   // Clock and reset
   input  wire logic                clk_sys,
   input  wire logic                rst,
   // Serial byte port
   input  wire cfgci_pkg::cfgci_spi_t spiIn,
   input  wire logic [23:0]         readBack,
   input  wire logic                readBackVld,
   // Words
   output logic [23:0]              cmdWord,
   output logic [23:0]              dat1Word,
   output logic [23:0]              dat2Word,
   output logic                     cmdStrobe
);
   logic [23:0] cmd_ff;
   logic [23:0] first_data_word_ff;
   logic [23:0] second_data_word_ff;
   logic        strobe_ff;

   wire inCmd  = spiIn.addr >= cfgci_pkg::SA_CMD  && spiIn.addr < cfgci_pkg::SA_FIRST_DATA_WORD;
   wire inDat1 = spiIn.addr >= cfgci_pkg::SA_FIRST_DATA_WORD && spiIn.addr < cfgci_pkg::SA_SECOND_DATA_WORD;
   wire inDat2 = spiIn.addr >= cfgci_pkg::SA_SECOND_DATA_WORD && spiIn.addr <= cfgci_pkg::SA_LAST;
   wire [7:0] offCmd  = spiIn.addr - cfgci_pkg::SA_CMD;
   wire [7:0] offDat1 = spiIn.addr - cfgci_pkg::SA_FIRST_DATA_WORD;
   wire [7:0] offDat2 = spiIn.addr - cfgci_pkg::SA_SECOND_DATA_WORD;
   // Last byte of the command word fires execution
   wire cmdDone = spiIn.wr && spiIn.addr == cfgci_pkg::SA_FIRST_DATA_WORD - 8'h01;

   function automatic logic [23:0] putByte(input logic [23:0] w, input logic [7:0] off,
                                           input logic [7:0] b);
      logic [23:0] r;
      r = w;
      case (off)
         8'h00: r[23:16] = b;
         8'h01: r[15:8]  = b;
         default: r[7:0] = b;
      endcase
      return r;
   endfunction

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         cmd_ff    <= 24'h00_0000;
         first_data_word_ff   <= 24'h00_0000;
         second_data_word_ff   <= 24'h00_0000;
         strobe_ff <= 1'b0;
      end else begin
         strobe_ff <= cmdDone;
         if (spiIn.wr && inCmd) begin
            cmd_ff <= putByte(cmd_ff, offCmd, spiIn.data);
         end
         if (readBackVld) begin
            first_data_word_ff <= readBack;
         end else if (spiIn.wr && inDat1) begin
            first_data_word_ff <= putByte(first_data_word_ff, offDat1, spiIn.data);
         end
         if (spiIn.wr && inDat2) begin
            second_data_word_ff <= putByte(second_data_word_ff, offDat2, spiIn.data);
         end
      end
   end

   assign cmdWord   = cmd_ff;
   assign dat1Word  = first_data_word_ff;
   assign dat2Word  = second_data_word_ff;
   assign cmdStrobe = strobe_ff;

   // Strobe must see the whole word, low byte included
   property p_cmd_strobe;
      @(posedge clk_sys) disable iff (rst)
      cmdDone |=> cmdStrobe && cmdWord[7:0] == $past(spiIn.data);
   endproperty
   a_cmd_strobe: assert property (p_cmd_strobe) else $error("Command strobe missing");
endmodule
`default_nettype wire

// File: testbench/cfgci_host_model.sv
// Host controller and boot memory model feeding the interpreter.
// Assumes the bench calls its tasks; inputs move 1 ns after a clock edge.
`timescale 1ns/1ps
`default_nettype none
module cfgci_host_model (
   // Clock
   input  wire logic             clk_sys,
   // Filter register file
   input  wire logic [11:0]      regRdIndex,
   output logic [23:0]           regRdData,
   // Command paths
   output cfgci_pkg::cfgci_spi_t spiIn,
   output logic                  bootMode,
   output logic                  bootValid,
   output logic [23:0]           bootWord
);
   // Contents follow the index so any read is predictable
   assign regRdData = {12'h5A5, regRdIndex};
   initial begin
      spiIn     = '0;
      bootMode  = 1'b0;
      bootValid = 1'b0;
      bootWord  = 24'h00_0000;
   end
   task automatic set_boot(input logic m);
      @(posedge clk_sys);
      #1;
      bootMode = m;
   endtask
   // Idle bus shows inverted data so stale bytes never look valid
   task automatic put_byte(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      #1;
      spiIn = '{wr: 1'b1, addr: a, data: d};
      @(posedge clk_sys);
      #1;
      spiIn = '{wr: 1'b0, addr: ~a, data: ~d};
   endtask
   task automatic put_word(input logic [7:0] a, input logic [23:0] w);
      put_byte(a, w[23:16]);
      put_byte(a + 8'h01, w[15:8]);
      put_byte(a + 8'h02, w[7:0]);
   endtask
   // Data words first: the last command byte launches it
   task automatic host_cmd(input logic [23:0] c, input logic [23:0] d1,
                           input logic [23:0] d2);
      put_word(cfgci_pkg::SA_FIRST_DATA_WORD, d1);
      put_word(cfgci_pkg::SA_SECOND_DATA_WORD, d2);
      put_word(cfgci_pkg::SA_CMD, c);
      repeat (6) @(posedge clk_sys);
   endtask
   task automatic boot_word(input logic [23:0] w);
      @(posedge clk_sys);
      #1;
      bootValid = 1'b1;
      bootWord  = w;
      @(posedge clk_sys);
      #1;
      bootValid = 1'b0;
      bootWord  = ~w;
   endtask
endmodule
`default_nettype wire

// File: testbench/cfgci_bench.sv
// Self-checking bench for the configuration command interpreter.
// Assumes the host model drives all command inputs; reset from here.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) \
   begin \
      checks_done++; \
      if ((g) !== (e)) begin \
         num_errors++; \
         $display("unexpected %s: expected %h seen %h", nm, e, g); \
      end \
   end
module cfgci_bench;
   logic                    clk_sys = 1'b0;
   logic                    rst     = 1'b1;
   cfgci_pkg::cfgci_spi_t   spiIn;
   logic                    bootMode;
   logic                    bootValid;
   logic [23:0]             bootWord;
   logic [23:0]             regRdData;
   cfgci_pkg::cfgci_store_t store;
   cfgci_pkg::cfgci_ctl_t   ctl;
   logic                    running;
   logic [23:0]             waveCount;
   logic [11:0]             regRdIndex;
   logic [23:0]             hostDat1;
   int                      num_errors  = 0;
   int                      checks_done = 0;
   int                      nStart      = 0;
   int                      nRomTbs     = 0;
   cfgci_pkg::cfgci_store_t seen[$];
   always #4 clk_sys = ~clk_sys;
   cfgci_top cfgci_top_inst (.clk_sys(clk_sys), .rst(rst), .spiIn(spiIn),
      .bootMode(bootMode), .bootValid(bootValid), .bootWord(bootWord),
      .regRdData(regRdData), .store(store), .ctl(ctl), .running(running),
      .waveCount(waveCount), .regRdIndex(regRdIndex), .hostDat1(hostDat1),
      .busy());
   cfgci_host_model cfgci_host_model_inst (.clk_sys(clk_sys),
      .regRdIndex(regRdIndex), .regRdData(regRdData), .spiIn(spiIn),
      .bootMode(bootMode), .bootValid(bootValid), .bootWord(bootWord));
   always @(posedge clk_sys) begin
      if (store.regWr || store.coefWr) seen.push_back(store);
      if (ctl.start) nStart++;
      if (ctl.romTbs) nRomTbs++;
   end
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic cmd(input logic [23:0] c, input logic [23:0] a, input logic [23:0] b);
      cfgci_host_model_inst.host_cmd(c, a, b);
   endtask
   task automatic bw(input logic [23:0] w);
      cfgci_host_model_inst.boot_word(w);
   endtask
   // Register writes carry no destination, so it is not compared
   task automatic exp_store(input logic rw, input cfgci_pkg::cfgci_dst_t d,
                            input logic [11:0] i, input logic [23:0] v);
      cfgci_pkg::cfgci_store_t e;
      cfgci_pkg::cfgci_store_t g;
      e = '{regWr: rw, coefWr: ~rw, dst: d, index: i, data: v};
      g = '0;
      if (seen.size() > 0) g = seen.pop_front();
      if (rw) g.dst = d;
      `CHK("store", e, g)
   endtask
   task automatic t_host_regs();
      cmd(cfgci_pkg::HC_WRREG, 24'h00_0020, 24'hAB_CDEF);
      exp_store(1'b1, cfgci_pkg::CFGCI_DST_FIR, 12'h020, 24'hAB_CDEF);
      cmd(cfgci_pkg::HC_RDREG, 24'h00_002A, 24'h00_0000);
      `CHK("readback", 24'h5A_502A, hostDat1)
      `CHK("extra stores", 0, seen.size())
   endtask
   task automatic t_run_reconfig();
      cmd(cfgci_pkg::HC_START, 24'h00_0000, 24'h00_0000);
      `CHK("running", 1'b1, running)
      `CHK("start pulses", 1, nStart)
      cmd(cfgci_pkg::HC_WRREG, 24'h00_0021, 24'h12_3456);
      exp_store(1'b1, cfgci_pkg::CFGCI_DST_FIR, 12'h021, 24'h12_3456);
      cmd(cfgci_pkg::HC_STOP, 24'h00_0000, 24'h00_0000);
      `CHK("stopped", 1'b0, running)
   endtask
   task automatic t_ignored();
      logic [23:0] codes[3] = '{cfgci_pkg::HC_NOP, 24'h00_000A, 24'hFF_FFFF};
      foreach (codes[k]) cmd(codes[k], 24'h00_0022, 24'h00_0055);
      `CHK("ignored stores", 0, seen.size())
      `CHK("ignored run", 1'b0, running)
   endtask
   task automatic t_host_lists();
      for (int k = 0; k < 4; k++)
         cmd(cfgci_pkg::HC_IIR, 24'h11_0000 + 24'(2 * k), 24'h11_0001 + 24'(2 * k));
      for (int k = 0; k < 8; k++)
         exp_store(1'b0, cfgci_pkg::CFGCI_DST_IIR, 12'(k), 24'h11_0000 + 24'(k));
      cmd(cfgci_pkg::HC_FIR, 24'h00_0001, 24'h00_0001);
      cmd(cfgci_pkg::HC_FIR, 24'h22_0000, 24'h22_0001);
      exp_store(1'b0, cfgci_pkg::CFGCI_DST_FIR, 12'h000, 24'h22_0000);
      exp_store(1'b0, cfgci_pkg::CFGCI_DST_FIR, 12'h001, 24'h22_0001);
      cmd(cfgci_pkg::HC_TBS, 24'h00_0002, 24'h00_0000);
      cmd(cfgci_pkg::HC_TBS, 24'h33_0000, 24'h33_0001);
      exp_store(1'b0, cfgci_pkg::CFGCI_DST_TBS, 12'h000, 24'h33_0000);
      exp_store(1'b0, cfgci_pkg::CFGCI_DST_TBS, 12'h001, 24'h33_0001);
      `CHK("wave count", 24'h00_0002, waveCount)
      cmd(cfgci_pkg::HC_ROMTBS, 24'h00_0000, 24'h00_0000);
      `CHK("rom waveform", 1, nRomTbs)
      cmd(cfgci_pkg::HC_ROMCOEF, 24'h00_1234, 24'h00_0000);
      `CHK("coef select", 24'h00_1234, ctl.coefSel)
   endtask
   task automatic t_boot();
      cfgci_host_model_inst.set_boot(1'b1);
      cmd(cfgci_pkg::HC_START, 24'h00_0000, 24'h00_0000);
      `CHK("host in boot", 1, nStart)
      bw(24'h00_0000);
      bw(24'h00_0001);
      bw(24'h00_0023);
      bw(24'h44_5566);
      bw(24'h00_0003);
      for (int k = 0; k < 8; k++) bw(24'h55_0000 + 24'(k));
      bw(24'h00_0002);
      bw(24'h00_0001);
      bw(24'h00_0001);
      bw(24'h66_0000);
      bw(24'h66_0001);
      bw(24'h00_0005);
      bw(24'h00_0001);
      bw(24'h77_0000);
      bw(24'h00_0006);
      bw(24'h00_0007);
      repeat (4) @(posedge clk_sys);
      exp_store(1'b1, cfgci_pkg::CFGCI_DST_FIR, 12'h023, 24'h44_5566);
      for (int k = 0; k < 8; k++)
         exp_store(1'b0, cfgci_pkg::CFGCI_DST_IIR, 12'(k), 24'h55_0000 + 24'(k));
      exp_store(1'b0, cfgci_pkg::CFGCI_DST_FIR, 12'h000, 24'h66_0000);
      exp_store(1'b0, cfgci_pkg::CFGCI_DST_FIR, 12'h001, 24'h66_0001);
      exp_store(1'b0, cfgci_pkg::CFGCI_DST_TBS, 12'h000, 24'h77_0000);
      `CHK("boot wave count", 24'h00_0001, waveCount)
      `CHK("boot rom waveform", 2, nRomTbs)
      `CHK("boot running", 1'b1, running)
      `CHK("boot extra", 0, seen.size())
   endtask
   initial begin
      repeat (2) @(posedge clk_sys);
      #1;
      rst = 1'b0;
      t_host_regs();
      t_run_reconfig();
      t_ignored();
      t_host_lists();
      t_boot();
      print_verdict();
   end
   // Hang guard well above the longest sequence
   initial begin
      repeat (20000) @(posedge clk_sys);
      num_errors++;
      print_verdict();
   end
endmodule
`default_nettype wire
